// ### host_audio_source.sv
// host serial audio controller model: bit clock, frame sync and two data pins
`timescale 1ns/10ps
module host_audio_source (
	// link pins towards the mapper
	output logic bclk,
	output logic fsync,
	output logic primary_data_in,
	output logic secondary_data_in
);
	logic fs_idle;

	// bclk stands low outside bursts
	initial begin
		bclk = 1'b0;
		fsync = 1'b0;
		fs_idle = 1'b0;
		primary_data_in = 1'b0;
		secondary_data_in = 1'b1;
	end

	// one bit: pins change while bclk is low, sampled on the rising edge
	task automatic bit_out(input logic fs, input logic p, input logic s);
		fsync = fs;
		primary_data_in = p;
		secondary_data_in = s;
		#15 bclk = 1'b1;
		#15 bclk = 1'b0;
	endtask : bit_out

	// clocks with no word; data toggles so a stale bit never looks held
	task automatic idle(input int n);
		repeat (n) bit_out(fs_idle, ~primary_data_in, ~secondary_data_in);
	endtask : idle

	// 32 slots of 16 bits, msb first; slot n carries base plus n on each pin
	task automatic send_frame(input logic [1:0] fmt, input logic [15:0] bp, input logic [15:0] bs);
		int d;
		int k;
		logic fs;
		logic [15:0] wp;
		logic [15:0] ws;
		d = (fmt == rx_map_pkg::FMT_I2S) ? 1 : 0;
		fs_idle = (fmt == rx_map_pkg::FMT_I2S);
		idle(8);
		for (int b = 0; b < 512 + d; b++) begin
			k = (b + 512 - d) % 512;
			case (fmt)
				rx_map_pkg::FMT_I2S: fs = (b >= 256);
				rx_map_pkg::FMT_LJ:  fs = (b < 256);
				default:             fs = (b == 0);
			endcase
			wp = bp + 16'(k / 16);
			ws = bs + 16'(k / 16);
			bit_out(fs, wp[15 - k % 16], ws[15 - k % 16]);
		end
		idle(8);
	endtask : send_frame
endmodule : host_audio_source

// ### rx_map_checker.sv
// assertions on the slot mapper's register port and sample outputs
`timescale 1ns/10ps
module rx_map_checker (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// samples
	input wire logic [31:0] dac_chan2_data,
	input wire logic        dac_chan1_valid,
	input wire logic        dac_chan2_valid,
	input wire logic        dac_chan3_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic       wrote;
	logic [7:0] rst_exp;

	// reset values only hold until the first write anywhere
	always_ff @(posedge ref_clk) begin
		wrote <= rst ? 1'b0 : (wrote | reg_wr);
		case (reg_addr)
			8'h28:   rst_exp <= 8'h20;
			8'h29:   rst_exp <= 8'h21;
			8'h2a:   rst_exp <= 8'h02;
			8'h2f:   rst_exp <= 8'h0c;
			default: rst_exp <= 8'h00;
		endcase
	end

	sequence s_rd_same;
		reg_rd && reg_addr == $past(reg_addr);
	endsequence
	property p_reset_vals;
		reg_rd && !wrote && reg_addr != 8'h30 |=> reg_rdata == rst_exp;
	endproperty
	property p_pin_readback;
		(reg_wr && reg_addr == 8'h27) ##1 s_rd_same |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	property p_chan_readback;
		(reg_wr && reg_addr inside {8'h28, 8'h29, 8'h2a}) ##1 s_rd_same
			|=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f);
	endproperty
	property p_reserved_zero;
		reg_rd && reg_addr inside {8'h28, 8'h29, 8'h2a} |=> reg_rdata[7:6] == 2'b00;
	endproperty
	property p_valid1_pulse;
		dac_chan1_valid |=> !dac_chan1_valid;
	endproperty
	property p_valid2_pulse;
		$rose(dac_chan2_valid) |=> $fell(dac_chan2_valid);
	endproperty
	property p_data2_with_valid;
		$changed(dac_chan2_data) |-> dac_chan2_valid;
	endproperty
	property p_valid3_spaced;
		dac_chan3_valid |=> !dac_chan3_valid [*8];
	endproperty

	a_reset_vals: assert property (p_reset_vals)
		else $error("register differs from reset value");
	a_pin_readback: assert property (p_pin_readback)
		else $error("pin select readback wrong");
	a_chan_readback: assert property (p_chan_readback)
		else $error("channel config readback wrong");
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved config bits not zero");
	a_valid1_pulse: assert property (p_valid1_pulse)
		else $error("channel 1 valid longer than one cycle");
	a_valid2_pulse: assert property (p_valid2_pulse)
		else $error("channel 2 valid longer than one cycle");
	a_data2_with_valid: assert property (p_data2_with_valid)
		else $error("channel 2 data changed without valid");
	a_valid3_spaced: assert property (p_valid3_spaced)
		else $error("channel 3 words too close together");
endmodule : rx_map_checker

// ### rx_map_pkg.sv
// constants and helpers for the receive slot mapper
package rx_map_pkg;

	// register offsets
	localparam logic [7:0] OFF_PIN_SELECT = 8'h27;
	localparam logic [7:0] OFF_CHAN1      = 8'h28;
	localparam logic [7:0] OFF_CHAN2      = 8'h29;
	localparam logic [7:0] OFF_CHAN3      = 8'h2a;
	localparam logic [7:0] OFF_FORMAT     = 8'h2f;
	localparam logic [7:0] OFF_STATUS     = 8'h30;

	// reset values
	localparam logic [7:0] RST_PIN_SELECT = 8'h00;
	localparam logic [7:0] RST_CHAN1      = 8'h20;
	localparam logic [7:0] RST_CHAN2      = 8'h21;
	localparam logic [7:0] RST_CHAN3      = 8'h02;
	localparam logic [7:0] RST_FORMAT     = 8'h0c;

	// field positions
	localparam int ENABLE_BIT = 5;
	localparam int SLOT_MSB   = 4;
	localparam int HALF_BIT   = 4;
	localparam int FMT_MSB    = 1;
	localparam int WLEN_LSB   = 2;
	localparam int WLEN_MSB   = 3;

	// format codes
	localparam logic [1:0] FMT_TDM = 2'h0;
	localparam logic [1:0] FMT_I2S = 2'h1;
	localparam logic [1:0] FMT_LJ  = 2'h2;

	// sizes
	localparam int NUM_CHAN = 3;
	localparam int WORD_W   = 32;
	localparam int POS_W    = 11;
	localparam logic [POS_W-1:0] POS_MAX = 11'h7ff;

	// bits per slot from the word length code
	function automatic logic [5:0] word_bits(input logic [1:0] code);
		case (code)
			2'h0:    word_bits = 6'h10;
			2'h1:    word_bits = 6'h14;
			2'h2:    word_bits = 6'h18;
			default: word_bits = 6'h20;
		endcase
	endfunction : word_bits

endpackage : rx_map_pkg

// ### rx_slot_capture.sv
// one receive channel: picks its pin and shifts in its slot on the bit clock
`timescale 1ns/10ps
module rx_slot_capture (
	// link clock and reset
	input  wire logic                          bclk,
	input  wire logic                          lrst,
	// frame position of the current bit
	input  wire logic [rx_map_pkg::POS_W-1:0]  bit_pos,
	input  wire logic                          right_half,
	input  wire logic                          primary_bit,
	input  wire logic                          secondary_bit,
	// channel setup, already in the link domain
	input  wire logic                          chan_enable,
	input  wire logic                          pin_select,
	input  wire logic [4:0]                    chan_slot,
	input  wire logic                          lr_mode,
	input  wire logic [1:0]                    wlen_code,
	// finished word and its toggle
	output logic      [rx_map_pkg::WORD_W-1:0] word_out,
	output logic                               done_tog
);

	logic [rx_map_pkg::WORD_W-1:0] shift;
	logic [rx_map_pkg::WORD_W-1:0] next_shift;
	logic [rx_map_pkg::WORD_W-1:0] next_word_out;
	logic                          next_done_tog;
	logic [rx_map_pkg::POS_W-1:0]  wbits;
	logic [rx_map_pkg::POS_W-1:0]  start;
	logic [rx_map_pkg::POS_W-1:0]  slot_idx;
	logic                          data_bit;
	logic                          half_ok;
	logic                          in_win;
	logic [rx_map_pkg::WORD_W-1:0] shifted;

	// slot window; in left/right formats the top slot bit names the half
	always_comb begin
		data_bit = pin_select ? secondary_bit : primary_bit;
		wbits    = {5'h00, rx_map_pkg::word_bits(wlen_code)};
		slot_idx = lr_mode ? {7'h00, chan_slot[3:0]} : {6'h00, chan_slot};
		start    = rx_map_pkg::POS_W'(slot_idx * wbits);
		half_ok  = !lr_mode || (right_half == chan_slot[rx_map_pkg::HALF_BIT]);
		in_win   = chan_enable && half_ok && (bit_pos >= start)
			&& (bit_pos < rx_map_pkg::POS_W'(start + wbits));
		shifted  = (bit_pos == start) ? {31'h0000_0000, data_bit} : {shift[30:0], data_bit};
		next_shift    = shift;
		next_word_out = word_out;
		next_done_tog = done_tog;
		if (in_win) begin
			next_shift = shifted;
			if (bit_pos == rx_map_pkg::POS_W'(start + wbits - 11'h001)) begin
				next_word_out = shifted;
				next_done_tog = !done_tog;
			end
		end
	end

	// registers; a disabled channel keeps its last word
	always_ff @(posedge bclk) begin
		if (lrst) begin
			shift    <= '0;
			word_out <= '0;
			done_tog <= 1'b0;
		end else begin
			shift    <= next_shift;
			word_out <= next_word_out;
			done_tog <= next_done_tog;
		end
	end

endmodule : rx_slot_capture

// ### serial_audio_rx_slot_mapper.sv
// receive slot mapper: registers, config crossing, frame tracking, word hand-off
`timescale 1ns/10ps
module serial_audio_rx_slot_mapper (
	// system clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// primary serial audio port pins
	input  wire logic        bclk,
	input  wire logic        fsync,
	input  wire logic        primary_data_in,
	input  wire logic        secondary_data_in,
	// samples towards the dac channels
	output logic      [31:0] dac_chan1_data,
	output logic             dac_chan1_valid,
	output logic      [31:0] dac_chan2_data,
	output logic             dac_chan2_valid,
	output logic      [31:0] dac_chan3_data,
	output logic             dac_chan3_valid
);

	localparam int N = rx_map_pkg::NUM_CHAN;

	// software visible state
	logic [7:0]        rx_pin_select;
	logic [N-1:0]      chan_en;
	logic [N-1:0][4:0] chan_slot;
	logic [3:0]        rx_format;
	logic [N-1:0]      sample_seen;
	logic [7:0]        next_pin_select;
	logic [N-1:0]      next_chan_en;
	logic [N-1:0][4:0] next_chan_slot;
	logic [3:0]        next_format;
	logic [N-1:0]      next_sample_seen;
	logic [7:0]        next_rdata;

	// config hand-off towards the link
	logic              cfg_pending;
	logic              cfg_busy;
	logic              cfg_req_tog;
	logic [N-1:0]      hold_sel;
	logic [N-1:0]      hold_en;
	logic [N-1:0][4:0] hold_slot;
	logic [3:0]        hold_format;
	logic              next_cfg_pending;
	logic              next_cfg_busy;
	logic              next_cfg_req_tog;
	logic [N-1:0]      next_hold_sel;
	logic [N-1:0]      next_hold_en;
	logic [N-1:0][4:0] next_hold_slot;
	logic [3:0]        next_hold_format;
	logic              ack_meta;
	logic              ack_sync;

	// word hand-off from the link
	logic [N-1:0]      done_meta;
	logic [N-1:0]      done_sync;
	logic [N-1:0]      done_seen;
	logic [N-1:0]      new_word;
	logic [N-1:0][31:0] link_word;
	logic [N-1:0]      link_done;
	logic [N-1:0][31:0] dac_data;
	logic [N-1:0][31:0] next_dac_data;
	logic [N-1:0]      dac_valid;

	// link domain state
	logic              lrst_meta;
	logic              lrst;
	logic              req_meta;
	logic              req_sync;
	logic              req_seen;
	logic [N-1:0]      link_sel;
	logic [N-1:0]      link_en;
	logic [N-1:0][4:0] link_slot;
	logic [3:0]        link_format;
	logic              fs_q;
	logic              fs_qq;
	logic              fs_q3;
	logic              prim_q;
	logic              sec_q;
	logic [rx_map_pkg::POS_W-1:0] pos;
	logic [rx_map_pkg::POS_W-1:0] cur_pos;
	logic              frame_edge;
	logic              right_half;
	logic              lr_mode;
	logic [1:0]        link_fmt;

	// register writes, status and read mux
	always_comb begin
		next_pin_select  = rx_pin_select;
		next_chan_en     = chan_en;
		next_chan_slot   = chan_slot;
		next_format      = rx_format;
		next_sample_seen = sample_seen;
		next_rdata       = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				rx_map_pkg::OFF_PIN_SELECT: next_pin_select = reg_wdata;
				rx_map_pkg::OFF_CHAN1: begin
					next_chan_en[0]   = reg_wdata[rx_map_pkg::ENABLE_BIT];
					next_chan_slot[0] = reg_wdata[rx_map_pkg::SLOT_MSB:0];
				end
				rx_map_pkg::OFF_CHAN2: begin
					next_chan_en[1]   = reg_wdata[rx_map_pkg::ENABLE_BIT];
					next_chan_slot[1] = reg_wdata[rx_map_pkg::SLOT_MSB:0];
				end
				rx_map_pkg::OFF_CHAN3: begin
					next_chan_en[2]   = reg_wdata[rx_map_pkg::ENABLE_BIT];
					next_chan_slot[2] = reg_wdata[rx_map_pkg::SLOT_MSB:0];
				end
				rx_map_pkg::OFF_FORMAT: next_format = reg_wdata[rx_map_pkg::WLEN_MSB:0];
				rx_map_pkg::OFF_STATUS: next_sample_seen = sample_seen & ~reg_wdata[N-1:0];
				default: ;
			endcase
		end
		// a word landing on the clearing cycle still sets the flag
		next_sample_seen = next_sample_seen | new_word;
		if (reg_rd) begin
			case (reg_addr)
				rx_map_pkg::OFF_PIN_SELECT: next_rdata = rx_pin_select;
				rx_map_pkg::OFF_CHAN1:  next_rdata = {2'h0, chan_en[0], chan_slot[0]};
				rx_map_pkg::OFF_CHAN2:  next_rdata = {2'h0, chan_en[1], chan_slot[1]};
				rx_map_pkg::OFF_CHAN3:  next_rdata = {2'h0, chan_en[2], chan_slot[2]};
				rx_map_pkg::OFF_FORMAT: next_rdata = {4'h0, rx_format};
				rx_map_pkg::OFF_STATUS: next_rdata = {cfg_busy, 4'h0, sample_seen};
				default:                next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_pin_select <= rx_map_pkg::RST_PIN_SELECT;
			chan_en       <= {rx_map_pkg::RST_CHAN3[rx_map_pkg::ENABLE_BIT],
				rx_map_pkg::RST_CHAN2[rx_map_pkg::ENABLE_BIT],
				rx_map_pkg::RST_CHAN1[rx_map_pkg::ENABLE_BIT]};
			chan_slot     <= {rx_map_pkg::RST_CHAN3[rx_map_pkg::SLOT_MSB:0],
				rx_map_pkg::RST_CHAN2[rx_map_pkg::SLOT_MSB:0],
				rx_map_pkg::RST_CHAN1[rx_map_pkg::SLOT_MSB:0]};
			rx_format     <= rx_map_pkg::RST_FORMAT[rx_map_pkg::WLEN_MSB:0];
			sample_seen   <= '0;
			reg_rdata     <= 8'h00;
		end else begin
			rx_pin_select <= next_pin_select;
			chan_en       <= next_chan_en;
			chan_slot     <= next_chan_slot;
			rx_format     <= next_format;
			sample_seen   <= next_sample_seen;
			reg_rdata     <= next_rdata;
		end
	end

	// config launch: hold is frozen while a request is in flight
	always_comb begin
		next_cfg_pending = cfg_pending;
		next_cfg_busy    = cfg_busy;
		next_cfg_req_tog = cfg_req_tog;
		next_hold_sel    = hold_sel;
		next_hold_en     = hold_en;
		next_hold_slot   = hold_slot;
		next_hold_format = hold_format;
		if (cfg_busy && (ack_sync == cfg_req_tog))
			next_cfg_busy = 1'b0;
		if (cfg_pending && !cfg_busy) begin
			next_hold_sel    = rx_pin_select[N-1:0];
			next_hold_en     = chan_en;
			next_hold_slot   = chan_slot;
			next_hold_format = rx_format;
			next_cfg_req_tog = !cfg_req_tog;
			next_cfg_busy    = 1'b1;
			next_cfg_pending = 1'b0;
		end
		if (reg_wr && (reg_addr >= rx_map_pkg::OFF_PIN_SELECT)
			&& (reg_addr <= rx_map_pkg::OFF_FORMAT) && (reg_addr != rx_map_pkg::OFF_STATUS))
			next_cfg_pending = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_pending <= 1'b0;
			cfg_busy    <= 1'b0;
			cfg_req_tog <= 1'b0;
			hold_sel    <= '0;
			hold_en     <= '0;
			hold_slot   <= '0;
			hold_format <= '0;
		end else begin
			cfg_pending <= next_cfg_pending;
			cfg_busy    <= next_cfg_busy;
			cfg_req_tog <= next_cfg_req_tog;
			hold_sel    <= next_hold_sel;
			hold_en     <= next_hold_en;
			hold_slot   <= next_hold_slot;
			hold_format <= next_hold_format;
		end
	end

	// synchronisers into the system clock
	always_ff @(posedge ref_clk) begin
		ack_meta  <= req_seen;
		ack_sync  <= ack_meta;
		done_meta <= link_done;
		done_sync <= done_meta;
	end

	// word pick-up; the link word is steady for a whole frame after its toggle
	always_comb begin
		new_word      = done_sync ^ done_seen;
		next_dac_data = dac_data;
		for (int i = 0; i < N; i++) begin
			if (new_word[i])
				next_dac_data[i] = link_word[i];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_seen <= '0;
			dac_data  <= '0;
			dac_valid <= '0;
		end else begin
			done_seen <= done_sync;
			dac_data  <= next_dac_data;
			dac_valid <= new_word;
		end
	end

	// link side reset; bclk may stop, so this only acts while frames run
	always_ff @(posedge bclk) begin
		lrst_meta <= rst;
		lrst      <= lrst_meta;
		req_meta  <= cfg_req_tog;
		req_sync  <= req_meta;
	end

	// link config takes the hold on each new request
	always_ff @(posedge bclk) begin
		if (lrst) begin
			req_seen    <= 1'b0;
			link_sel    <= rx_map_pkg::RST_PIN_SELECT[N-1:0];
			link_en     <= 3'h3;
			link_slot   <= {5'h02, 5'h01, 5'h00};
			link_format <= rx_map_pkg::RST_FORMAT[rx_map_pkg::WLEN_MSB:0];
		end else begin
			req_seen <= req_sync;
			if (req_sync != req_seen) begin
				link_sel    <= hold_sel;
				link_en     <= hold_en;
				link_slot   <= hold_slot;
				link_format <= hold_format;
			end
		end
	end

	// frame tracking; I2S starts its word one bit after the sync change
	always_comb begin
		link_fmt = link_format[rx_map_pkg::FMT_MSB:0];
		lr_mode  = (link_fmt != rx_map_pkg::FMT_TDM);
		case (link_fmt)
			rx_map_pkg::FMT_I2S: begin
				frame_edge = fs_qq != fs_q3;
				right_half = fs_qq;
			end
			rx_map_pkg::FMT_LJ: begin
				frame_edge = fs_q != fs_qq;
				right_half = !fs_q;
			end
			default: begin
				frame_edge = fs_q && !fs_qq;
				right_half = 1'b0;
			end
		endcase
		if (frame_edge)
			cur_pos = '0;
		else if (pos == rx_map_pkg::POS_MAX)
			cur_pos = pos;
		else
			cur_pos = rx_map_pkg::POS_W'(pos + 11'h001);
	end

	always_ff @(posedge bclk) begin
		if (lrst) begin
			fs_q   <= 1'b0;
			fs_qq  <= 1'b0;
			fs_q3  <= 1'b0;
			prim_q <= 1'b0;
			sec_q  <= 1'b0;
			pos    <= rx_map_pkg::POS_MAX;
		end else begin
			fs_q   <= fsync;
			fs_qq  <= fs_q;
			fs_q3  <= fs_qq;
			prim_q <= primary_data_in;
			sec_q  <= secondary_data_in;
			pos    <= cur_pos;
		end
	end

	// one capture per mapped channel
	for (genvar g = 0; g < N; g++) begin : g_chan
		rx_slot_capture u_cap (
			.bclk          (bclk),
			.lrst          (lrst),
			.bit_pos       (cur_pos),
			.right_half    (right_half),
			.primary_bit   (prim_q),
			.secondary_bit (sec_q),
			.chan_enable   (link_en[g]),
			.pin_select    (link_sel[g]),
			.chan_slot     (link_slot[g]),
			.lr_mode       (lr_mode),
			.wlen_code     (link_format[rx_map_pkg::WLEN_MSB:rx_map_pkg::WLEN_LSB]),
			.word_out      (link_word[g]),
			.done_tog      (link_done[g])
		);
	end

	// outputs straight from flops
	assign dac_chan1_data  = dac_data[0];
	assign dac_chan2_data  = dac_data[1];
	assign dac_chan3_data  = dac_data[2];
	assign dac_chan1_valid = dac_valid[0];
	assign dac_chan2_valid = dac_valid[1];
	assign dac_chan3_valid = dac_valid[2];

endmodule : serial_audio_rx_slot_mapper

// ### serial_audio_rx_slot_mapper_tb.sv
// testbench for the receive slot mapper: register access and framed traffic
`timescale 1ns/10ps
module serial_audio_rx_slot_mapper_tb;
	logic        ref_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        bclk;
	logic        fsync;
	logic        primary_data_in;
	logic        secondary_data_in;
	logic [31:0] dac_data [3];
	logic [2:0]  dac_valid;
	logic [31:0] got [3];
	int          n_valid [3] = '{0, 0, 0};
	int          n_mismatch = 0;
	int          checks = 0;

	serial_audio_rx_slot_mapper i_dut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk(bclk),
		.fsync(fsync), .primary_data_in(primary_data_in),
		.secondary_data_in(secondary_data_in),
		.dac_chan1_data(dac_data[0]), .dac_chan1_valid(dac_valid[0]),
		.dac_chan2_data(dac_data[1]), .dac_chan2_valid(dac_valid[1]),
		.dac_chan3_data(dac_data[2]), .dac_chan3_valid(dac_valid[2])
	);

	host_audio_source i_host (
		.bclk(bclk), .fsync(fsync), .primary_data_in(primary_data_in),
		.secondary_data_in(secondary_data_in)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// last word and word count per channel; valid stands one cycle only
	always @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (dac_valid[i] === 1'b1) begin
				got[i] <= dac_data[i];
				n_valid[i] <= n_valid[i] + 1;
			end
		end
	end

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk_word

	// strobes end with a 1 ns step so the next call never reassigns them at the edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		checks++;
		if (reg_rdata !== exp) begin
			n_mismatch++;
			$display("mismatch reg %h expected %h seen %h", a, exp, reg_rdata);
		end
	endtask : rd_chk

	// one frame, then room for the crossing to the ref side
	task automatic frame(input logic [1:0] fmt);
		i_host.send_frame(fmt, 16'h5a00, 16'ha500);
		repeat (20) @(posedge ref_clk);
		#1;
	endtask : frame

	task automatic final_report;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// three frames of about 16 us each; far beyond that means a hang
	initial begin
		#300000;
		n_mismatch++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// the link reset needs bclk edges while rst is high
		fork
			i_host.idle(3);
		join_none
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		wait fork;
		i_host.idle(8);
		@(posedge ref_clk);
		#1;
		rd_chk(8'h27, 8'h00);
		rd_chk(8'h28, 8'h20);
		rd_chk(8'h29, 8'h21);
		rd_chk(8'h2a, 8'h02);
		rd_chk(8'h26, 8'h00);
		wr(8'h27, 8'hff);
		rd_chk(8'h27, 8'hff);
		wr(8'h2a, 8'h3f);
		rd_chk(8'h2a, 8'h3f);
		wr(8'h26, 8'h55);
		rd_chk(8'h26, 8'h00);
		// tdm, 16-bit slots, channels 2 and 3 on the secondary pin
		wr(8'h2f, 8'h00);
		wr(8'h27, 8'h06);
		wr(8'h28, 8'h3f);
		wr(8'h29, 8'h20);
		wr(8'h2a, 8'h31);
		frame(rx_map_pkg::FMT_TDM);
		chk_word("chan1 tdm", 32'h00005a1f, got[0]);
		chk_word("chan2 tdm", 32'h0000a500, got[1]);
		chk_word("chan3 tdm", 32'h0000a511, got[2]);
		// left/right formats, channel 3 switched off
		wr(8'h27, 8'h01);
		wr(8'h28, 8'h30);
		wr(8'h29, 8'h2f);
		wr(8'h2a, 8'h11);
		for (int f = 1; f < 3; f++) begin
			wr(8'h2f, 8'(f));
			frame(2'(f));
			chk_word("chan1 right", 32'h0000a510, got[0]);
			chk_word("chan2 left", 32'h00005a0f, got[1]);
			chk_word("chan3 held", 32'h0000a511, got[2]);
			chk_word("chan1 count", 32'(f + 1), 32'(n_valid[0]));
			chk_word("chan2 count", 32'(f + 1), 32'(n_valid[1]));
			chk_word("chan3 count", 32'h00000001, 32'(n_valid[2]));
		end
		// sticky word flags: every channel has delivered, a write of ones clears them
		rd_chk(8'h30, 8'h07);
		wr(8'h30, 8'h07);
		rd_chk(8'h30, 8'h00);
		final_report();
	end
endmodule : serial_audio_rx_slot_mapper_tb

bind serial_audio_rx_slot_mapper rx_map_checker i_chk (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.dac_chan2_data(dac_chan2_data), .dac_chan1_valid(dac_chan1_valid),
	.dac_chan2_valid(dac_chan2_valid), .dac_chan3_valid(dac_chan3_valid)
);
